/* design/ddr_pkg.sv */
// package for the drive data register bank
package ddr_pkg;
  // register indices (two-digit register numbers)
  localparam logic [7:0] ADDR_ACCEL = 8'h11;
  localparam logic [7:0] ADDR_DECEL = 8'h12;
  localparam logic [7:0] ADDR_CHG_DIST = 8'h13;
  localparam logic [7:0] ADDR_MOVE_DIST = 8'h14;
  localparam logic [7:0] ADDR_POS_OFS = 8'h15;
  localparam logic [7:0] ADDR_FLAGS = 8'h16;
  localparam logic [7:0] ADDR_CURRENT = 8'h17;
  localparam logic [7:0] ADDR_GAIN = 8'h18;
  localparam logic [7:0] ADDR_EDGE_CNT = 8'h19;
  // unit scale: 10 rpm/sec per lsb is six per rev/sec/sec
  localparam logic [15:0] RATE_SCALE = 16'h0006;
  // flag bit positions
  localparam int FLAG_DIST_LIMIT = 0;
  localparam int FLAG_SENSOR = 1;
  localparam int FLAG_OVC_A = 2;
  localparam int FLAG_OVC_B = 3;
  localparam int FLAG_OFS_A = 5;
  localparam int FLAG_OFS_B = 6;
  localparam int FLAG_WIND_A = 7;
  localparam int FLAG_WIND_B = 8;
  localparam int FLAG_ERASE = 14;
  localparam int FLAG_SAVE = 15;
  // reset values and gain limits
  localparam logic [15:0] RST_RATE = 16'h0258;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [15:0] GAIN_MAX = 16'h7FFF;
  localparam logic [15:0] GAIN_MIN = 16'h8001;

  // register read/write request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ddr_req_t;

  // hardware events
  typedef struct packed {
    logic dist_limit;
    logic sensor;
    logic ovc_a;
    logic ovc_b;
    logic ofs_a;
    logic ofs_b;
    logic wind_a;
    logic wind_b;
    logic erase_fail;
    logic save_fail;
  } ddr_evt_t;

  // all block state except the set position
  typedef struct packed {
    logic [15:0] accel;
    logic [15:0] decel;
    logic [31:0] chg_dist;
    logic [31:0] move_dist;
    logic [31:0] pos_ofs;
    logic [31:0] flags;
    logic [15:0] current;
    logic [15:0] gain;
    logic [31:0] edge_cnt;
    logic [31:0] rdata;
    logic rvalid;
  } ddr_state_t;
endpackage : ddr_pkg

/* design/ddr_bank.sv */
// drive data register bank with sticky flag word
// Contract
// - accel held as six times rev/s^2
// - decel held as six times rev/s^2
// - registers use integer values only
// - offset equals encoder minus set position
// - flag bits 0-3 limit sensor overcurrents
// - bits 5,6 report bad current offset
// - bits 7,8 report open winding
// - loading zero clears all flags, except any bit whose event fires in the same cycle
// - gain signed, clamp to +/-32767
`timescale 1ns/100ps
module ddr_bank
  import ddr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ddr_req_t req,
  input wire logic accel_cmd_load,
  input wire logic decel_cmd_load,
  input wire logic [15:0] rate_cmd_value,
  input wire logic set_position_load,
  input wire logic [31:0] set_position_value,
  input wire logic [31:0] encoder_count,
  input wire logic edge_pulse,
  input wire ddr_evt_t evt,
  output logic [31:0] rdata,
  output logic rvalid,
  output logic [15:0] accel_rate,
  output logic [15:0] decel_rate,
  output logic [31:0] flags_out,
  output logic [15:0] gain_out
);
  ddr_state_t s, next_s;
  logic [31:0] set_pos;
  logic [31:0] next_set_pos;

  // saturate a signed 32-bit write value to the symmetric 16-bit gain range
  function automatic logic [15:0] clamp_gain(input logic [31:0] v);
    if ($signed(v) > $signed({16'h0000, GAIN_MAX}))
      return GAIN_MAX;
    if ($signed(v) < -$signed({16'h0000, GAIN_MAX}))
      return GAIN_MIN;
    return v[15:0];
  endfunction : clamp_gain

  // flag set mask from events
  function automatic logic [31:0] evt_mask(input ddr_evt_t e);
    logic [31:0] m;
    m = RST_WORD;
    m[FLAG_DIST_LIMIT] = e.dist_limit;
    m[FLAG_SENSOR] = e.sensor;
    m[FLAG_OVC_A] = e.ovc_a;
    m[FLAG_OVC_B] = e.ovc_b;
    m[FLAG_OFS_A] = e.ofs_a;
    m[FLAG_OFS_B] = e.ofs_b;
    m[FLAG_WIND_A] = e.wind_a;
    m[FLAG_WIND_B] = e.wind_b;
    m[FLAG_ERASE] = e.erase_fail;
    m[FLAG_SAVE] = e.save_fail;
    return m;
  endfunction : evt_mask

  // next-state logic for every register
  always_comb begin
    next_s = s;
    next_set_pos = set_pos;
    next_s.rvalid = 1'b0;
    // integer-only storage, no fractional bits kept
    if (accel_cmd_load) begin
      next_s.accel = 16'(rate_cmd_value * RATE_SCALE);
    end
    if (decel_cmd_load) begin
      next_s.decel = 16'(rate_cmd_value * RATE_SCALE);
    end
    if (set_position_load) begin
      next_set_pos = set_position_value;
    end
    if (edge_pulse) begin
      next_s.edge_cnt = s.edge_cnt + 32'h0000_0001;
    end
    if (req.wr) begin
      unique case (req.addr)
        ADDR_ACCEL: next_s.accel = req.wdata[15:0];
        ADDR_DECEL: next_s.decel = req.wdata[15:0];
        ADDR_CHG_DIST: next_s.chg_dist = req.wdata;
        ADDR_MOVE_DIST: next_s.move_dist = req.wdata;
        ADDR_FLAGS: begin
          // only a zero load clears; other values are ignored
          if (req.wdata == RST_WORD) next_s.flags = RST_WORD;
        end
        ADDR_CURRENT: next_s.current = req.wdata[15:0];
        ADDR_GAIN: next_s.gain = clamp_gain(req.wdata);
        ADDR_EDGE_CNT: next_s.edge_cnt = req.wdata;
        default: ;
      endcase
      if (req.addr == ADDR_POS_OFS) begin
        // rebase set position so the offset reads back as written
        next_set_pos = encoder_count - req.wdata;
      end
    end
    // set wins over the clear in the same cycle
    next_s.flags = next_s.flags | evt_mask(evt);
    // offset tracks encoder against set position continuously
    next_s.pos_ofs = encoder_count - next_set_pos;
    if (req.rd) begin
      next_s.rvalid = 1'b1;
      unique case (req.addr)
        ADDR_ACCEL: next_s.rdata = {16'h0000, s.accel};
        ADDR_DECEL: next_s.rdata = {16'h0000, s.decel};
        ADDR_CHG_DIST: next_s.rdata = s.chg_dist;
        ADDR_MOVE_DIST: next_s.rdata = s.move_dist;
        ADDR_POS_OFS: next_s.rdata = s.pos_ofs;
        ADDR_FLAGS: next_s.rdata = s.flags;
        ADDR_CURRENT: next_s.rdata = {{16{s.current[15]}}, s.current};
        ADDR_GAIN: next_s.rdata = {{16{s.gain[15]}}, s.gain};
        ADDR_EDGE_CNT: next_s.rdata = s.edge_cnt;
        default: next_s.rdata = RST_WORD;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{accel: RST_RATE, decel: RST_RATE, current: RST_HALF,
             gain: RST_HALF, rvalid: 1'b0, default: RST_WORD};
      set_pos <= RST_WORD;
    end else begin
      s <= next_s;
      set_pos <= next_set_pos;
    end
  end

  assign rdata = s.rdata;
  assign rvalid = s.rvalid;
  assign accel_rate = s.accel;
  assign decel_rate = s.decel;
  assign flags_out = s.flags;
  assign gain_out = s.gain;

  // checks
  accel_scale_a: assert property (@(posedge clk) disable iff (rst)
    accel_cmd_load && !(req.wr && req.addr == ADDR_ACCEL) |=>
    accel_rate == 16'($past(rate_cmd_value) * RATE_SCALE))
    else $error("accel not six times command");
  decel_scale_a: assert property (@(posedge clk) disable iff (rst)
    decel_cmd_load && !(req.wr && req.addr == ADDR_DECEL) |=>
    decel_rate == 16'($past(rate_cmd_value) * RATE_SCALE))
    else $error("decel not six times command");
  offset_track_a: assert property (@(posedge clk) disable iff (rst)
    !set_position_load && !(req.wr && req.addr == ADDR_POS_OFS) |=>
    s.pos_ofs == $past(encoder_count) - set_pos)
    else $error("offset mismatch");
  flag_set_a: assert property (@(posedge clk) disable iff (rst)
    evt.ovc_a |=> flags_out[FLAG_OVC_A])
    else $error("overcurrent flag missed");
  flag_ofs_a: assert property (@(posedge clk) disable iff (rst)
    evt.ofs_b |=> flags_out[FLAG_OFS_B])
    else $error("offset flag missed");
  flag_wind_a: assert property (@(posedge clk) disable iff (rst)
    evt.wind_a |=> flags_out[FLAG_WIND_A])
    else $error("winding flag missed");
  flag_clear_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ADDR_FLAGS && req.wdata == RST_WORD &&
    evt_mask(evt) == RST_WORD |=> flags_out == RST_WORD)
    else $error("flags not cleared");
  gain_range_a: assert property (@(posedge clk) disable iff (rst)
    gain_out != 16'h8000)
    else $error("gain out of range");
  flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
    flags_out[FLAG_SENSOR] && !(req.wr && req.addr == ADDR_FLAGS) |=>
    flags_out[FLAG_SENSOR])
    else $error("flag dropped");
  // a clear load may legally follow, so persistence is checked for one more cycle only when no flag write comes
  flag_flash_a: assert property (@(posedge clk) disable iff (rst)
    evt.save_fail |=> flags_out[FLAG_SAVE] and
    (!(req.wr && req.addr == ADDR_FLAGS) |=> flags_out[FLAG_SAVE]))
    else $error("flash flag missed");
  // each remaining event bit latches on the next edge
  flag_limit_a: assert property (@(posedge clk) disable iff (rst)
    evt.dist_limit |=> flags_out[FLAG_DIST_LIMIT])
    else $error("limit flag missed");
  flag_sensor_a: assert property (@(posedge clk) disable iff (rst)
    evt.sensor |=> flags_out[FLAG_SENSOR])
    else $error("sensor flag missed");
  flag_ovcb_a: assert property (@(posedge clk) disable iff (rst)
    evt.ovc_b |=> flags_out[FLAG_OVC_B])
    else $error("second overcurrent flag missed");
  flag_ofsa_a: assert property (@(posedge clk) disable iff (rst)
    evt.ofs_a |=> flags_out[FLAG_OFS_A])
    else $error("phase a offset flag missed");
  flag_windb_a: assert property (@(posedge clk) disable iff (rst)
    evt.wind_b |=> flags_out[FLAG_WIND_B])
    else $error("phase b winding flag missed");
  flag_erase_a: assert property (@(posedge clk) disable iff (rst)
    evt.erase_fail |=> flags_out[FLAG_ERASE])
    else $error("erase flag missed");
  // a nonzero load must never drop a flag
  flag_keep_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ADDR_FLAGS && req.wdata != RST_WORD |=>
    (flags_out & $past(flags_out)) == $past(flags_out))
    else $error("nonzero load dropped a flag");
  // bus writes land as plain integers and beat a same-cycle command
  rate_write_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ADDR_ACCEL |=>
    accel_rate == $past(req.wdata[15:0]))
    else $error("accel write lost");
  decel_write_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ADDR_DECEL |=>
    decel_rate == $past(req.wdata[15:0]))
    else $error("decel write lost");
  offset_write_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ADDR_POS_OFS |=> s.pos_ofs == $past(req.wdata))
    else $error("offset write not read back");
  offset_load_a: assert property (@(posedge clk) disable iff (rst)
    set_position_load && !(req.wr && req.addr == ADDR_POS_OFS) |=>
    s.pos_ofs == $past(encoder_count) - $past(set_position_value))
    else $error("offset after set position wrong");
  gain_pass_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ADDR_GAIN &&
    $signed(req.wdata) <= $signed({16'h0000, GAIN_MAX}) &&
    $signed(req.wdata) >= -$signed({16'h0000, GAIN_MAX}) |=>
    gain_out == $past(req.wdata[15:0]))
    else $error("in-range gain altered");
  gain_high_a: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == ADDR_GAIN &&
    $signed(req.wdata) > $signed({16'h0000, GAIN_MAX}) |=>
    gain_out == GAIN_MAX)
    else $error("high gain not clamped");
endmodule : ddr_bank

/* dv/ddr_host.sv */
// host model issuing register load and read commands
`timescale 1ns/100ps
module ddr_host
  import ddr_pkg::*;
(
  input wire logic clk,
  input wire logic [31:0] rdata,
  output ddr_req_t req
);
  // held across the taking edge; released data is inverted, never kept
  task automatic access(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk) #1 req = '{w, !w, a, d};
    @(posedge clk) #1 req = '{1'b0, 1'b0, a, ~d};
    q = rdata;
  endtask : access
  initial req = '0;
endmodule : ddr_host

/* dv/ddr_bank_tb.sv */
// self-checking bench for the drive data register bank
`timescale 1ns/100ps
module ddr_bank_tb;
  import ddr_pkg::*;
  logic clk, rst, acl, dcl, spl, edg, rvalid;
  logic [15:0] rate, acc, dec, gain;
  logic [31:0] spv, enc, rdata, flags, q, seed, e, d;
  logic [7:0] a;
  ddr_req_t req;
  ddr_evt_t evt;
  int num_errors, compares, cyc;
  logic [31:0] mdl [logic [7:0]];
  int pos [10] = '{0, 1, 2, 3, 5, 6, 7, 8, 14, 15};
  ddr_bank u_dut (.clk(clk), .rst(rst), .req(req), .accel_cmd_load(acl),
    .decel_cmd_load(dcl), .rate_cmd_value(rate), .set_position_load(spl),
    .set_position_value(spv), .encoder_count(enc), .edge_pulse(edg),
    .evt(evt), .rdata(rdata), .rvalid(rvalid), .accel_rate(acc),
    .decel_rate(dec), .flags_out(flags), .gain_out(gain));
  ddr_host u_host (.clk(clk), .rdata(rdata), .req(req));
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // what a register holds after a bus write of v
  function automatic logic [31:0] fit(logic [7:0] r, logic [31:0] v);
    int s;
    s = $signed(v);
    if (r == ADDR_GAIN) return s > 32767 ? 32'h7FFF : s < -32767 ? -32767 : v;
    if (r == ADDR_CURRENT) return {{16{v[15]}}, v[15:0]};
    if (r < ADDR_CHG_DIST) return {16'h0, v[15:0]};
    return v;
  endfunction : fit
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    compares++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  // read via the host, compare with the model
  task automatic rd_chk(logic [7:0] r);
    u_host.access(1'b0, r, 32'h0, q);
    chk("rvalid", {31'h0, rvalid}, 32'h1);
    chk("rdata", q, mdl.exists(r) ? mdl[r] : 32'h0);
  endtask : rd_chk
  task automatic conclude();
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // hang guard, far above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    seed = 32'h592C;
    {rst, acl, dcl, spl, edg} = 5'h10;
    {rate, spv, enc} = '0;
    evt = '0;
    for (int i = 8'h11; i < 8'h1A; i++) mdl[i] = i < 8'h13 ? 32'h258 : 32'h0;
    repeat (20) @(posedge clk);
    #1 rst = 0;
    // reset values, then one unmapped index
    for (int i = 8'h11; i < 8'h1B; i++) rd_chk(i[7:0]);
    // random writes read back; nonzero flag writes must be ignored
    for (int i = 0; i < 30; i++) begin
      a = 8'h11 + 8'(rnd() % 9);
      d = rnd();
      if (d[0]) d = {{16{d[31]}}, d[31:16]};
      if (a < ADDR_CHG_DIST) d[0] = 1'b1;
      u_host.access(1'b1, a, d, q);
      if (a != ADDR_FLAGS || d == 0) mdl[a] = fit(a, d);
      rd_chk(a);
      if (a == ADDR_GAIN) chk("gain", {{16{gain[15]}}, gain}, mdl[a]);
    end
    // rate commands scale by six
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) #1 {acl, dcl} = k ? 2'b01 : 2'b10;
      rate = 16'(rnd());
      rate[0] = 1'b1;
      @(posedge clk) #1 {acl, dcl} = 2'b00;
      e = {16'h0, rate * 16'h6};
      chk("rate", {16'h0, k ? dec : acc}, e);
      mdl[ADDR_ACCEL + 8'(k)] = e;
      rd_chk(ADDR_ACCEL + 8'(k));
    end
    // each event sticks after it drops
    e = 0;
    for (int k = 0; k < 10; k++) begin
      @(posedge clk) #1 evt = 10'h200 >> k;
      @(posedge clk) #1 evt = '0;
      e[pos[k]] = 1'b1;
      chk("flags", flags, e);
    end
    mdl[ADDR_FLAGS] = e;
    u_host.access(1'b1, ADDR_FLAGS, 32'h5, q);
    rd_chk(ADDR_FLAGS);
    u_host.access(1'b1, ADDR_FLAGS, 32'h0, q);
    mdl[ADDR_FLAGS] = 0;
    rd_chk(ADDR_FLAGS);
    // offset tracks encoder minus set position
    enc = rnd();
    spv = rnd();
    @(posedge clk) #1 spl = 1;
    @(posedge clk) #1 spl = 0;
    mdl[ADDR_POS_OFS] = enc - spv;
    rd_chk(ADDR_POS_OFS);
    enc = enc + 32'h5;
    mdl[ADDR_POS_OFS] += 5;
    rd_chk(ADDR_POS_OFS);
    // a run of edge cycles
    d = rnd() % 8 + 1;
    @(posedge clk) #1 edg = 1;
    repeat (d) @(posedge clk);
    #1 edg = 0;
    mdl[ADDR_EDGE_CNT] += d;
    rd_chk(ADDR_EDGE_CNT);
    conclude();
  end
endmodule : ddr_bank_tb
